// [sync_rx_core.sv]
// Synchronous serial receiver: sync hunt, framing, parity and status word
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Character into output register sets char ready.
// - Status word: ready bit0, overrun bit1, parity bit2, sync bit3.
// - Sync flag follows shift register equal to sync register.
// - Low status enable, with read enable high, drives status onto the receive outputs.
// - Status enable rising edge clears fill, overrun, parity, sync flags.
// - Transfer while ready still set sets overrun, old character lost.
// - Overrun also clears on ready rising, restart low, reset.
// - Parity error set when character parity disagrees with selection.
// - Parity error clears on good character, strobe end, restart, reset.
// - Restart low holds receiver reset and clears all four flags.
// - Restart rising edge starts bit-by-bit sync hunt.
// - Hunt compares only the configured number of data bits.
// - First match sets sync, loads output, then frames whole words.
// - First sync character skips parity check, later ones checked.
// - Length select 00,01,10,11 gives five to eight bits.
// - Length counts data bits; parity bit extra when enabled.
// - Unused receive bits read low, data right-justified at bit zero.
// - Parity disable skips checking and holds parity error low.
// - Parity select high means even parity, low means odd.
// - Control inputs latched while control strobe is low.
// - Low read enable drives output register onto receive outputs.
// - Serial data shifted least significant bit first.
// - Each bit sampled on falling edge of receive clock.
// - Fill flag shown on status bit six.
`timescale 1ns/1ps
module sync_rx_core (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic serial_rx_in_i,
    input wire logic rx_bit_clock_i,
    input wire logic receiver_restart_n_i,
    input wire logic status_word_enable_n_i,
    input wire logic rx_output_enable_n_i,
    input wire logic control_strobe_n_i,
    input wire logic char_len_sel_lo_i,
    input wire logic char_len_sel_hi_i,
    input wire logic parity_disable_i,
    input wire logic parity_even_sel_i,
    input wire logic [sync_rx_pkg::DATA_W-1:0] sync_char_i,
    input wire logic fill_char_sent_i,
    output logic [sync_rx_pkg::DATA_W-1:0] rx_data_o,
    output logic rx_data_oe_o,
    output logic char_ready_flag_o,
    output logic sync_match_flag_o,
    output logic overrun_flag_o,
    output logic parity_error_flag_o,
    output logic fill_char_sent_flag_o,
    output logic [sync_rx_pkg::DATA_W-1:0] fifo_data_o,
    output logic fifo_valid_o,
    input wire logic fifo_ready_i,
    output logic rx_stall_o
);
    import sync_rx_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic rcp_prev;
        logic swe_prev;
        logic rde_prev;
        logic rr_prev;
        logic [1:0] len_sel;
        logic par_dis;
        logic par_even;
        logic [7:0] sync_reg;
        rx_state_t state;
        logic [8:0] shift;
        logic [3:0] bit_cnt;
        logic first_char;
        logic [7:0] out_reg;
        logic ready;
        logic sync_match;
        logic overrun;
        logic par_err;
        logic fill;
        logic [7:0] rx_data;
        logic oe;
        logic push;
        logic [7:0] push_data;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    logic fifo_in_ready;

    // Pin indexes in the synchroniser vectors
    localparam int P_RCP = 0;
    localparam int P_RSI = 1;
    localparam int P_RR = 2;
    localparam int P_SWE = 3;
    localparam int P_RDE = 4;
    localparam int P_CS = 5;

    function automatic logic [7:0] len_mask(input logic [1:0] sel);
        logic [3:0] n;
        n = LEN_BASE + {2'h0, sel};
        len_mask = 8'hff >> (4'h8 - n);
    endfunction : len_mask

    always_comb
    begin
        logic [5:0] pins;
        logic rcp_fall;
        logic swe_rise;
        logic rde_rise;
        logic rr_rise;
        logic rr_low;
        logic [3:0] data_n;
        logic [3:0] frame_n;
        logic [8:0] sh;
        logic [7:0] mask;
        logic [7:0] chr;
        logic par_bit;
        logic par_ok;
        logic xfer;
        logic check_par;
        logic [7:0] status;
        pins = {control_strobe_n_i, rx_output_enable_n_i, status_word_enable_n_i,
            receiver_restart_n_i, serial_rx_in_i, rx_bit_clock_i};
        st_next = st_reg;
        st_next.push = 1'b0;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.rcp_prev = st_reg.sync2[P_RCP];
        st_next.swe_prev = st_reg.sync2[P_SWE];
        st_next.rde_prev = st_reg.sync2[P_RDE];
        st_next.rr_prev = st_reg.sync2[P_RR];
        rcp_fall = st_reg.rcp_prev && !st_reg.sync2[P_RCP];
        swe_rise = !st_reg.swe_prev && st_reg.sync2[P_SWE];
        rde_rise = !st_reg.rde_prev && st_reg.sync2[P_RDE];
        rr_rise = !st_reg.rr_prev && st_reg.sync2[P_RR];
        rr_low = !st_reg.sync2[P_RR];

        // Control register follows the inputs while the strobe is low
        if (!st_reg.sync2[P_CS])
        begin
            st_next.len_sel = {char_len_sel_hi_i, char_len_sel_lo_i};
            st_next.par_dis = parity_disable_i;
            st_next.par_even = parity_even_sel_i;
            st_next.sync_reg = sync_char_i;
        end

        data_n = LEN_BASE + {2'h0, st_reg.len_sel};
        frame_n = data_n + {3'h0, !st_reg.par_dis};
        mask = len_mask(st_reg.len_sel);
        xfer = 1'b0;
        check_par = 1'b0;
        sh = st_reg.shift;
        chr = 8'h00;

        // ****************************************************************
        // Receive framing
        // ****************************************************************
        if (rcp_fall && fifo_in_ready && st_reg.state != ST_IDLE)
        begin
            // New bit enters at the top of the frame, so bits land LSB first
            sh = (st_reg.shift >> 1);
            // Hunt window holds data bits only, so the parity slot stays out of it
            if (st_reg.state == ST_HUNT)
                sh[data_n - 4'h1] = st_reg.sync2[P_RSI];
            else
                sh[frame_n - 4'h1] = st_reg.sync2[P_RSI];
            st_next.shift = sh;
            if (st_reg.state == ST_HUNT)
            begin
                chr = sh[7:0] & mask;
                if (chr == (st_reg.sync_reg & mask))
                begin
                    xfer = 1'b1;
                    st_next.sync_match = 1'b1;
                    st_next.state = ST_WORD;
                    st_next.bit_cnt = CNT_RESET;
                    st_next.shift = '0;
                end
            end
            else if (st_reg.bit_cnt == frame_n - 4'h1)
            begin
                chr = sh[7:0] & mask;
                xfer = 1'b1;
                check_par = !st_reg.par_dis && !st_reg.first_char;
                st_next.bit_cnt = CNT_RESET;
                st_next.shift = '0;
                st_next.sync_match = (chr == (st_reg.sync_reg & mask));
            end
            else
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end

        par_bit = sh[data_n];
        par_ok = ((^chr) ^ par_bit) == !st_reg.par_even;

        if (xfer)
        begin
            st_next.out_reg = chr;
            st_next.first_char = 1'b0;
            st_next.push = 1'b1;
            st_next.push_data = chr;
            if (st_reg.ready)
                st_next.overrun = 1'b1;
            st_next.ready = 1'b1;
            if (check_par)
                st_next.par_err = !par_ok;
        end

        // Status clears; transfer-driven sets win over strobe ends
        if (!st_reg.ready && st_next.ready)
            st_next.overrun = 1'b0;
        if (rde_rise && !xfer)
            st_next.ready = 1'b0;
        if (swe_rise)
        begin
            st_next.fill = 1'b0;
            if (!xfer)
            begin
                st_next.overrun = 1'b0;
                st_next.par_err = 1'b0;
                st_next.sync_match = 1'b0;
            end
        end
        if (fill_char_sent_i)
            st_next.fill = 1'b1;
        if (st_reg.par_dis)
            st_next.par_err = 1'b0;

        if (rr_low)
        begin
            st_next.ready = 1'b0;
            st_next.sync_match = 1'b0;
            st_next.overrun = 1'b0;
            st_next.par_err = 1'b0;
            st_next.state = ST_IDLE;
            st_next.push = 1'b0;
        end
        else if (rr_rise)
        begin
            st_next.state = ST_HUNT;
            st_next.shift = '0;
            st_next.bit_cnt = CNT_RESET;
            st_next.first_char = 1'b1;
        end

        // ****************************************************************
        // Parallel output mux
        // ****************************************************************
        status = 8'h00;
        status[STAT_READY_BIT] = st_reg.ready;
        status[STAT_OVERRUN_BIT] = st_reg.overrun;
        status[STAT_PARITY_BIT] = st_reg.par_err;
        status[STAT_SYNC_BIT] = st_reg.sync_match;
        status[STAT_FILL_BIT] = st_reg.fill;
        st_next.oe = 1'b0;
        st_next.rx_data = 8'h00;
        if (!st_reg.sync2[P_RDE])
        begin
            st_next.rx_data = st_reg.out_reg;
            st_next.oe = 1'b1;
        end
        else if (!st_reg.sync2[P_SWE])
        begin
            st_next.rx_data = status;
            st_next.oe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_reg <= '0;
            st_reg.sync1 <= 6'h3f;
            st_reg.sync2 <= 6'h3f;
            st_reg.rcp_prev <= 1'b1;
            st_reg.swe_prev <= 1'b1;
            st_reg.rde_prev <= 1'b1;
            st_reg.rr_prev <= 1'b1;
            st_reg.len_sel <= LEN_SEL_RESET;
            st_reg.sync_reg <= SYNC_CHAR_RESET;
            st_reg.par_dis <= 1'b1;
            st_reg.state <= ST_IDLE;
        end
        else if (clk_en_i)
            st_reg <= st_next;
    end

    // ****************************************************************
    // Character FIFO
    // ****************************************************************
    sync_rx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .in_data_i(st_reg.push_data),
        .in_valid_i(st_reg.push),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_data_o),
        .out_valid_o(fifo_valid_o),
        .out_ready_i(fifo_ready_i)
    );

    assign rx_data_o = st_reg.rx_data;
    assign rx_data_oe_o = st_reg.oe;
    assign char_ready_flag_o = st_reg.ready;
    assign sync_match_flag_o = st_reg.sync_match;
    assign overrun_flag_o = st_reg.overrun;
    assign parity_error_flag_o = st_reg.par_err;
    assign fill_char_sent_flag_o = st_reg.fill;
    assign rx_stall_o = !fifo_in_ready;
endmodule : sync_rx_core

// [sync_rx_core_properties.sv]
// Concurrent checks on the synchronous receiver core ports
`timescale 1ns/1ps
module rx_core_checker (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic receiver_restart_n_i,
    input wire logic status_word_enable_n_i,
    input wire logic rx_output_enable_n_i,
    input wire logic control_strobe_n_i,
    input wire logic parity_disable_i,
    input wire logic fill_char_sent_i,
    input wire logic [sync_rx_pkg::DATA_W-1:0] rx_data_o,
    input wire logic rx_data_oe_o,
    input wire logic char_ready_flag_o,
    input wire logic sync_match_flag_o,
    input wire logic overrun_flag_o,
    input wire logic parity_error_flag_o,
    input wire logic fill_char_sent_flag_o,
    input wire logic rx_stall_o
);
    import sync_rx_pkg::*;
    logic [DATA_W-1:0] flag_word;
    assign flag_word = {1'b0, fill_char_sent_flag_o, 2'h0, sync_match_flag_o,
        parity_error_flag_o, overrun_flag_o, char_ready_flag_o};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    // ****************************************
    // Port relations
    // ****************************************
    chk_idle_out_low: assert property (
        (rx_output_enable_n_i && status_word_enable_n_i)[*6]
        |=> !rx_data_oe_o && rx_data_o == 8'h00)
        else $error("receive outputs driven with both strobes idle");
    chk_status_map: assert property (
        (!status_word_enable_n_i && rx_output_enable_n_i)[*6] ##0 $stable(flag_word)
        |=> rx_data_oe_o && rx_data_o == $past(flag_word))
        else $error("status word layout wrong");
    chk_read_clears_ready: assert property (
        $rose(rx_output_enable_n_i) |-> ##[1:6] !char_ready_flag_o)
        else $error("read strobe end left char ready set");
    chk_status_clears: assert property (
        $rose(status_word_enable_n_i) && !fill_char_sent_i |-> ##[1:6]
        !(overrun_flag_o || parity_error_flag_o || sync_match_flag_o || fill_char_sent_flag_o))
        else $error("status strobe end left flags set");
    chk_restart_clears: assert property (
        !receiver_restart_n_i[*6] |-> flag_word[3:0] == 4'h0)
        else $error("flags set while restart held low");
    chk_overrun_cause: assert property (
        $rose(overrun_flag_o) |-> $past(char_ready_flag_o) && char_ready_flag_o)
        else $error("overrun raised without pending character");
    chk_parity_off_low: assert property (
        (!control_strobe_n_i && parity_disable_i)[*6] |=> !parity_error_flag_o)
        else $error("parity error set with parity disabled");
    chk_sync_with_ready: assert property (
        $rose(sync_match_flag_o) |-> char_ready_flag_o)
        else $error("sync match without character transfer");
    chk_ready_rise_ovr: assert property (
        $rose(char_ready_flag_o) |-> ##[0:1] !overrun_flag_o)
        else $error("overrun not cleared by char ready rising");
    cover property ($rose(overrun_flag_o));
    cover property ($rose(parity_error_flag_o));
    cover property (rx_stall_o);
endmodule : rx_core_checker

bind sync_rx_core rx_core_checker chk (.sys_clk_i, .reset_i, .receiver_restart_n_i,
    .status_word_enable_n_i, .rx_output_enable_n_i, .control_strobe_n_i, .parity_disable_i,
    .fill_char_sent_i, .rx_data_o, .rx_data_oe_o, .char_ready_flag_o, .sync_match_flag_o,
    .overrun_flag_o, .parity_error_flag_o, .fill_char_sent_flag_o, .rx_stall_o);

// [sync_rx_fifo.sv]
// Parameterised valid/ready FIFO for received characters
`timescale 1ns/1ps
module sync_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic [WIDTH-1:0] out_data;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW])
        && (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
    assign empty = (st_reg.wr_ptr == st_reg.rd_ptr);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign out_data_o = st_reg.out_data;

    always_comb
    begin
        st_next = st_reg;
        if (push)
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        if (pop)
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        st_next.out_data = mem[st_next.rd_ptr[AW-1:0]];
        if (push && (st_next.rd_ptr[AW-1:0] == st_reg.wr_ptr[AW-1:0]))
            st_next.out_data = in_data_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            st_reg <= '0;
        else if (clk_en_i)
        begin
            st_reg <= st_next;
            if (push)
                mem[st_reg.wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule : sync_rx_fifo

// [sync_rx_pkg.sv]
// Package of constants and types for the synchronous serial receiver
package sync_rx_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] LEN_SEL_RESET = 2'h3;
    localparam logic [7:0] SYNC_CHAR_RESET = 8'h16;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;
    localparam int STAT_PARITY_BIT = 2;
    localparam int STAT_SYNC_BIT = 3;
    localparam int STAT_FILL_BIT = 6;
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [3:0] CNT_RESET = 4'h0;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_HUNT = 3'b010,
        ST_WORD = 3'b100
    } rx_state_t;
endpackage : sync_rx_pkg

// [sync_tx_model.sv]
// Behavioural model of the remote synchronous transmitter
`timescale 1ns/1ps
module sync_tx_model (
    output logic bit_clk_o,
    output logic data_o
);
    initial
    begin
        bit_clk_o = 1'b1;
        data_o = 1'b1;
    end
    // ****************************************
    // Frame sender, clock stands high between frames
    // ****************************************
    task automatic send(input logic [8:0] frame, input int n);
        for (int i = 0; i < n; i++)
        begin
            data_o = frame[i];
            #100 bit_clk_o = 1'b0;
            #100 bit_clk_o = 1'b1;
        end
        data_o = ~data_o;
    endtask : send
endmodule : sync_tx_model

// [testbench.sv]
// Self-checking bench for the synchronous receiver core
`timescale 1ns/1ps
module testbench;
    import sync_rx_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic parity_disable;
        logic even;
        logic bad;
        logic [7:0] data;
        logic [7:0] exp_data;
        logic exp_perr;
    } row_t;
    localparam row_t ROWS [5] = '{
        '{2'h0, 1'b1, 1'b0, 1'b1, 8'hff, 8'h1f, 1'b0},
        '{2'h1, 1'b0, 1'b0, 1'b0, 8'hea, 8'h2a, 1'b0},
        '{2'h2, 1'b0, 1'b1, 1'b1, 8'h5b, 8'h5b, 1'b1},
        '{2'h3, 1'b0, 1'b1, 1'b0, 8'hc3, 8'hc3, 1'b0},
        '{2'h3, 1'b0, 1'b0, 1'b1, 8'h81, 8'h81, 1'b1}};
    logic sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1;
    logic serial_rx_in_i, rx_bit_clock_i, receiver_restart_n_i = 1'b1;
    logic status_word_enable_n_i = 1'b1, rx_output_enable_n_i = 1'b1, control_strobe_n_i = 1'b0;
    logic char_len_sel_lo_i = 1'b1, char_len_sel_hi_i = 1'b1, parity_disable_i = 1'b1;
    logic parity_even_sel_i = 1'b0, fill_char_sent_i = 1'b0, fifo_ready_i = 1'b1;
    logic [7:0] sync_char_i = SYNC_CHAR_RESET, rx_data_o, fifo_data_o, mask = 8'hff;
    logic rx_data_oe_o, char_ready_flag_o, sync_match_flag_o, overrun_flag_o;
    logic parity_error_flag_o, fill_char_sent_flag_o, fifo_valid_o, rx_stall_o;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    sync_tx_model tx (.bit_clk_o(rx_bit_clock_i), .data_o(serial_rx_in_i));
    sync_rx_core dut (.sys_clk_i, .reset_i, .clk_en_i, .serial_rx_in_i, .rx_bit_clock_i,
        .receiver_restart_n_i, .status_word_enable_n_i, .rx_output_enable_n_i,
        .control_strobe_n_i, .char_len_sel_lo_i, .char_len_sel_hi_i, .parity_disable_i,
        .parity_even_sel_i, .sync_char_i, .fill_char_sent_i, .rx_data_o, .rx_data_oe_o,
        .char_ready_flag_o, .sync_match_flag_o, .overrun_flag_o, .parity_error_flag_o,
        .fill_char_sent_flag_o, .fifo_data_o, .fifo_valid_o, .fifo_ready_i, .rx_stall_o);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic send_char(input logic [7:0] d, input logic bad, input logic sync);
        logic [8:0] frame;
        int n;
        n = 5 + int'({char_len_sel_hi_i, char_len_sel_lo_i});
        frame = {1'b0, d & mask};
        frame[n] = ^(d & mask) ^ !parity_even_sel_i ^ bad;
        @(negedge sys_clk_i);
        tx.send(frame, n + ((sync || parity_disable_i) ? 0 : 1));
        tick(6);
    endtask : send_char
    task automatic look(input logic status, input logic [7:0] exp);
        if (status)
            status_word_enable_n_i <= 1'b0;
        else
            rx_output_enable_n_i <= 1'b0;
        tick(6);
        check(rx_data_o, exp);
        check(rx_data_oe_o, 1'b1);
        status_word_enable_n_i <= 1'b1;
        rx_output_enable_n_i <= 1'b1;
        tick(6);
    endtask : look
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("mismatch at %0t: run did not finish", $time);
            stop_test();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        tick(12);
        reset_i <= 1'b0;
        tick(2);
        check({rx_data_oe_o, char_ready_flag_o, overrun_flag_o, parity_error_flag_o}, 8'h0);
        foreach (ROWS[i])
        begin
            {char_len_sel_hi_i, char_len_sel_lo_i} <= ROWS[i].sel;
            parity_disable_i <= ROWS[i].parity_disable;
            parity_even_sel_i <= ROWS[i].even;
            mask = 8'hff >> (3 - ROWS[i].sel);
            receiver_restart_n_i <= 1'b0;
            tick(8);
            receiver_restart_n_i <= 1'b1;
            tick(6);
            send_char(sync_char_i, 1'b0, 1'b1);
            check({sync_match_flag_o, char_ready_flag_o, parity_error_flag_o}, 8'h6);
            look(1'b0, sync_char_i & mask);
            check(char_ready_flag_o, 1'b0);
            send_char(ROWS[i].data, ROWS[i].bad, 1'b0);
            check(parity_error_flag_o, ROWS[i].exp_perr);
            check(sync_match_flag_o, 1'b0);
            look(1'b1, {5'h0, ROWS[i].exp_perr, 2'h1});
            check(parity_error_flag_o, 1'b0);
            look(1'b0, ROWS[i].exp_data);
        end
        send_char(8'h3c, 1'b1, 1'b0);
        send_char(8'h3d, 1'b0, 1'b0);
        check({overrun_flag_o, parity_error_flag_o}, 8'h2);
        look(1'b0, 8'h3d);
        send_char(8'h3e, 1'b0, 1'b0);
        check({overrun_flag_o, char_ready_flag_o}, 8'h1);
        fill_char_sent_i <= 1'b1;
        tick(4);
        fill_char_sent_i <= 1'b0;
        tick(6);
        look(1'b1, 8'h41);
        check(fill_char_sent_flag_o, 1'b0);
        fifo_ready_i <= 1'b0;
        for (int k = 0; k < 17; k++)
            send_char(8'h40 + k[7:0], 1'b0, 1'b0);
        check(rx_stall_o, 1'b1);
        for (int k = 0; k < 16; k++)
        begin
            check(fifo_data_o, 8'h40 + k[7:0]);
            fifo_ready_i <= 1'b1;
            tick(1);
            fifo_ready_i <= 1'b0;
            tick(1);
        end
        check(fifo_valid_o, 1'b0);
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        tick(1);
        check({char_ready_flag_o, overrun_flag_o, fifo_valid_o, rx_data_oe_o}, 8'h0);
        stop_test();
    end
endmodule : testbench
